// File: rtl/alu_consts.svh
// constants for the integer add and logic datapath
`ifndef ALU_CONSTS_SVH
`define ALU_CONSTS_SVH
`define ALU_DATA_W 32
`define ALU_IMM_W 16
`define ALU_REG_IDX_W 5
`define ALU_ZERO_IDX 5'h00
`define ALU_ZERO_WORD 32'h0000_0000
`define ALU_ONES_WORD 32'hFFFF_FFFF
`define ALU_ZERO_HALF 16'h0000
`endif

// File: rtl/alu_pkg.sv
// types for the integer add and logic datapath
`default_nettype none
package alu_pkg;
    typedef enum logic [3:0] {
        OP_SUM, OP_SUM_CARRY, OP_SUM_EXT, OP_SUM_IMM, OP_SUM_IMM_CARRY,
        OP_SUM_IMM_CARRY_REC, OP_SUM_IMM_HIGH, OP_SUM_MINUS_ONE, OP_SUM_ZERO,
        OP_AND, OP_AND_COMPL, OP_AND_IMM_LOW, OP_AND_IMM_HIGH
    } alu_op_type;

    typedef struct packed {
        logic valid;
        alu_op_type op;
        logic [4:0] dest_idx;
        logic [4:0] source_a_idx;
        logic [31:0] source_a_reg;
        logic [31:0] source_b_reg;
        logic [31:0] value_source_reg;
        logic [15:0] imm16;
        logic overflow_enable;
        logic record_bit;
    } alu_req_type;

    typedef struct packed {
        logic negative_flag;
        logic positive_flag;
        logic zero_flag;
        logic sticky_flag;
    } result_field_type;

    typedef struct packed {
        logic valid;
        logic [4:0] dest_idx;
        logic [31:0] data;
    } alu_wb_type;
endpackage
`default_nettype wire

// File: rtl/integer_add_and_logic_alu.sv
// integer add and bitwise and execution stage with flag state
`include "alu_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module integer_add_and_logic_alu #(
    parameter int DATA_W = `ALU_DATA_W
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // request from decode and register file
    input wire alu_pkg::alu_req_type req_i,
    // result write-back
    output alu_pkg::alu_wb_type wb_o,
    // flag state
    output alu_pkg::result_field_type result_flag_field_o,
    output logic unsigned_out_flag_o,
    output logic signed_overflow_flag_o
);
    if (DATA_W != `ALU_DATA_W) begin : g_chk
        $error("datapath supports only a 32-bit width");
    end

    function automatic logic [31:0] sign_extend_fn(input logic [15:0] v);
        sign_extend_fn = {{16{v[15]}}, v};
    endfunction

    function automatic logic is_imm_sum(input alu_pkg::alu_op_type op);
        is_imm_sum = (op == alu_pkg::OP_SUM_IMM) || (op == alu_pkg::OP_SUM_IMM_HIGH);
    endfunction

    logic [31:0] add_a, add_b, add_c, logic_res, result;
    logic [31:0] and_operand, and_bits;
    logic [32:0] sum_full;
    logic is_add, carry_upd, carry_in_op, rec_upd, ov_allowed, dest_is_a, ov_now;
    logic sign_a, sign_b, sign_s;
    alu_pkg::result_field_type result_flag_field_r, field_nxt;
    logic unsigned_out_flag_r, signed_overflow_flag_r, sticky_now;
    alu_pkg::alu_wb_type wb_r;

    // control decode: each branch sets the whole control word, so no
    // operation silently inherits a default meant for another
    always_comb begin
        is_add = 1'b0;
        carry_upd = 1'b0;
        carry_in_op = 1'b0;
        rec_upd = 1'b0;
        ov_allowed = 1'b0;
        dest_is_a = 1'b1;
        case (req_i.op)
            // plain register sum
            alu_pkg::OP_SUM: begin
                is_add = 1'b1;
                carry_upd = 1'b0;
                carry_in_op = 1'b0;
                rec_upd = req_i.record_bit;
                ov_allowed = 1'b1;
                dest_is_a = 1'b0;
            end

            // register sum that reports the carry
            alu_pkg::OP_SUM_CARRY: begin
                is_add = 1'b1;
                carry_upd = 1'b1;
                carry_in_op = 1'b0;
                rec_upd = req_i.record_bit;
                ov_allowed = 1'b1;
                dest_is_a = 1'b0;
            end

            // register sum with carry in and out
            alu_pkg::OP_SUM_EXT: begin
                is_add = 1'b1;
                carry_upd = 1'b1;
                carry_in_op = 1'b1;
                rec_upd = req_i.record_bit;
                ov_allowed = 1'b1;
                dest_is_a = 1'b0;
            end

            // immediate sum touches no flag
            alu_pkg::OP_SUM_IMM: begin
                is_add = 1'b1;
                carry_upd = 1'b0;
                carry_in_op = 1'b0;
                rec_upd = 1'b0;
                ov_allowed = 1'b0;
                dest_is_a = 1'b0;
            end

            // immediate sum that reports the carry
            alu_pkg::OP_SUM_IMM_CARRY: begin
                is_add = 1'b1;
                carry_upd = 1'b1;
                carry_in_op = 1'b0;
                rec_upd = 1'b0;
                ov_allowed = 1'b0;
                dest_is_a = 1'b0;
            end

            // immediate carry sum that always records
            alu_pkg::OP_SUM_IMM_CARRY_REC: begin
                is_add = 1'b1;
                carry_upd = 1'b1;
                carry_in_op = 1'b0;
                rec_upd = 1'b1;
                ov_allowed = 1'b0;
                dest_is_a = 1'b0;
            end

            // upper-half immediate sum touches no flag
            alu_pkg::OP_SUM_IMM_HIGH: begin
                is_add = 1'b1;
                carry_upd = 1'b0;
                carry_in_op = 1'b0;
                rec_upd = 1'b0;
                ov_allowed = 1'b0;
                dest_is_a = 1'b0;
            end

            // source A plus carry minus one
            alu_pkg::OP_SUM_MINUS_ONE: begin
                is_add = 1'b1;
                carry_upd = 1'b1;
                carry_in_op = 1'b1;
                rec_upd = req_i.record_bit;
                ov_allowed = 1'b1;
                dest_is_a = 1'b0;
            end

            // source A plus carry
            alu_pkg::OP_SUM_ZERO: begin
                is_add = 1'b1;
                carry_upd = 1'b1;
                carry_in_op = 1'b1;
                rec_upd = req_i.record_bit;
                ov_allowed = 1'b1;
                dest_is_a = 1'b0;
            end

            // register conjunction
            alu_pkg::OP_AND: begin
                is_add = 1'b0;
                carry_upd = 1'b0;
                carry_in_op = 1'b0;
                rec_upd = req_i.record_bit;
                ov_allowed = 1'b0;
                dest_is_a = 1'b1;
            end

            // conjunction with inverted source B
            alu_pkg::OP_AND_COMPL: begin
                is_add = 1'b0;
                carry_upd = 1'b0;
                carry_in_op = 1'b0;
                rec_upd = req_i.record_bit;
                ov_allowed = 1'b0;
                dest_is_a = 1'b1;
            end

            // lower-half mask always records
            alu_pkg::OP_AND_IMM_LOW: begin
                is_add = 1'b0;
                carry_upd = 1'b0;
                carry_in_op = 1'b0;
                rec_upd = 1'b1;
                ov_allowed = 1'b0;
                dest_is_a = 1'b1;
            end

            // upper-half mask always records
            alu_pkg::OP_AND_IMM_HIGH: begin
                is_add = 1'b0;
                carry_upd = 1'b0;
                carry_in_op = 1'b0;
                rec_upd = 1'b1;
                ov_allowed = 1'b0;
                dest_is_a = 1'b1;
            end

            // unknown codes write zero and move no flag
            default: begin
                is_add = 1'b0;
                carry_upd = 1'b0;
                carry_in_op = 1'b0;
                rec_upd = 1'b0;
                ov_allowed = 1'b0;
                dest_is_a = 1'b1;
            end
        endcase
    end

    // adder operands
    always_comb begin
        add_a = req_i.source_a_reg;
        add_b = `ALU_ZERO_WORD;
        if (is_imm_sum(req_i.op) && req_i.source_a_idx == `ALU_ZERO_IDX) begin
            add_a = `ALU_ZERO_WORD;
        end
        case (req_i.op)
            alu_pkg::OP_SUM,
            alu_pkg::OP_SUM_CARRY,
            alu_pkg::OP_SUM_EXT: begin
                add_b = req_i.source_b_reg;
            end

            alu_pkg::OP_SUM_IMM,
            alu_pkg::OP_SUM_IMM_CARRY,
            alu_pkg::OP_SUM_IMM_CARRY_REC: begin
                add_b = sign_extend_fn(req_i.imm16);
            end

            alu_pkg::OP_SUM_IMM_HIGH: begin
                add_b = {req_i.imm16, `ALU_ZERO_HALF};
            end

            alu_pkg::OP_SUM_MINUS_ONE: begin
                add_b = `ALU_ONES_WORD;
            end

            default: begin
                add_b = `ALU_ZERO_WORD;
            end
        endcase
    end

    // carry-in word, zero for every operation that does not consume it
    assign add_c = carry_in_op ? {31'h0000_0000, unsigned_out_flag_r} : `ALU_ZERO_WORD;

    // second operand of the conjunction
    always_comb begin
        and_operand = `ALU_ZERO_WORD;
        case (req_i.op)
            alu_pkg::OP_AND: begin
                and_operand = req_i.source_b_reg;
            end

            alu_pkg::OP_AND_COMPL: begin
                and_operand = ~req_i.source_b_reg;
            end

            alu_pkg::OP_AND_IMM_LOW: begin
                and_operand = {`ALU_ZERO_HALF, req_i.imm16};
            end

            alu_pkg::OP_AND_IMM_HIGH: begin
                and_operand = {req_i.imm16, `ALU_ZERO_HALF};
            end

            default: begin
                and_operand = `ALU_ZERO_WORD;
            end
        endcase
    end

    // bitwise conjunction, one gate per bit
    for (genvar gi = 0; gi < DATA_W; gi++) begin : g_and_bit
        assign and_bits[gi] = req_i.value_source_reg[gi] & and_operand[gi];
    end
    assign logic_res = and_bits;

    assign sum_full = {1'b0, add_a} + {1'b0, add_b} + {1'b0, add_c};

    // write-back value: adder or conjunction
    always_comb begin
        if (is_add) begin
            result = sum_full[31:0];
        end else begin
            result = logic_res;
        end
    end

    // signed overflow: operands share a sign the truncated sum lacks
    always_comb begin
        sign_a = add_a[31];
        sign_b = add_b[31];
        sign_s = sum_full[31];
        ov_now = (sign_a == sign_b) && (sign_s != sign_a);
    end
    // overflow this cycle also feeds the sticky copy recorded now
    assign sticky_now = result_flag_field_r.sticky_flag
        | (is_add & ov_allowed & req_i.overflow_enable & ov_now);

    // per-byte zero detect keeps the wide compare shallow
    logic [3:0] byte_zero;
    for (genvar gb = 0; gb < 4; gb++) begin : g_byte_zero
        assign byte_zero[gb] = result[gb*8 +: 8] == 8'h00;
    end

    always_comb begin
        field_nxt.negative_flag = $signed(result) < 0;
        field_nxt.positive_flag = $signed(result) > 0;
        field_nxt.zero_flag = &byte_zero;
        field_nxt.sticky_flag = sticky_now;
    end

    // result write-back
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wb_r <= '0;
        end else begin
            wb_r.valid <= req_i.valid;
            wb_r.data <= result;
            // and forms target the source-A position
            wb_r.dest_idx <= dest_is_a ? req_i.source_a_idx : req_i.dest_idx;
        end
    end

    // carry flag
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            unsigned_out_flag_r <= 1'b0;
        end else if (req_i.valid && carry_upd) begin
            unsigned_out_flag_r <= sum_full[32];
        end
    end

    // overflow flag
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            signed_overflow_flag_r <= 1'b0;
        end else if (req_i.valid && is_add && ov_allowed && req_i.overflow_enable) begin
            signed_overflow_flag_r <= ov_now;
        end
    end

    // result field, sticky bit lives here too
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            result_flag_field_r <= '0;
        end else if (req_i.valid) begin
            if (rec_upd) begin
                result_flag_field_r <= field_nxt;
            end else begin
                result_flag_field_r.sticky_flag <= sticky_now;
            end
        end
    end

    assign wb_o = wb_r;
    assign result_flag_field_o = result_flag_field_r;
    assign unsigned_out_flag_o = unsigned_out_flag_r;
    assign signed_overflow_flag_o = signed_overflow_flag_r;
endmodule
`default_nettype wire

// File: verification/alu_checker_sva.sv
// port assertions for the add and logic datapath
`timescale 1ns/10ps
`default_nettype none
module alu_checker_sva (
    // watched ports
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire alu_pkg::alu_req_type req_i,
    input wire alu_pkg::alu_wb_type wb_o,
    input wire alu_pkg::result_field_type result_flag_field_o,
    input wire logic unsigned_out_flag_o,
    input wire logic signed_overflow_flag_o
);
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);
    alu_pkg::alu_op_type op;
    logic v;
    logic [31:0] a, b, s, ab;
    logic [15:0] m;
    assign op = req_i.op;
    assign v = req_i.valid;
    assign a = req_i.source_a_reg;
    assign b = req_i.source_b_reg;
    assign s = req_i.value_source_reg;
    assign m = req_i.imm16;
    assign ab = a + b;
    chk_wb_pulse: assert property (v |=> wb_o.valid) else $error("no wb");
    chk_plain_sum: assert property (v && op == alu_pkg::OP_SUM
        |=> wb_o.data == $past(a) + $past(b)) else $error("bad sum");
    chk_carry_out: assert property (v && op == alu_pkg::OP_SUM_CARRY
        |=> unsigned_out_flag_o == (33'($past(a)) + $past(b)) >> 32) else $error("bad carry");
    chk_imm_zero: assert property (v && op == alu_pkg::OP_SUM_IMM
        && req_i.source_a_idx == 5'h00 |=> wb_o.data == {{16{$past(m[15])}}, $past(m)})
        else $error("bad zero base");
    chk_imm_flags: assert property (v && op inside {alu_pkg::OP_SUM_IMM,
        alu_pkg::OP_SUM_IMM_HIGH} |=> $stable(result_flag_field_o) && $stable(unsigned_out_flag_o))
        else $error("flags moved");
    chk_no_record: assert property (v && !req_i.record_bit
        && op inside {alu_pkg::OP_SUM, alu_pkg::OP_AND} |=> $stable(result_flag_field_o[3:1]))
        else $error("field moved");
    chk_and_compl: assert property (v && op == alu_pkg::OP_AND_COMPL
        |=> wb_o.data == ($past(s) & ~$past(b)) && wb_o.dest_idx == $past(req_i.source_a_idx))
        else $error("bad and-compl");
    chk_mask_zero: assert property (v && op == alu_pkg::OP_AND_IMM_LOW
        |=> result_flag_field_o.zero_flag == (($past(s) & {16'h0000, $past(m)}) == '0))
        else $error("bad mask field");
    chk_ov_sets: assert property (v && op == alu_pkg::OP_SUM && req_i.overflow_enable
        && a[31] == b[31] && ab[31] != a[31]
        |=> signed_overflow_flag_o && result_flag_field_o.sticky_flag)
        else $error("overflow not set");
    chk_rec_always: assert property (v && op == alu_pkg::OP_SUM_IMM_CARRY_REC
        |=> result_flag_field_o.zero_flag == (($past(a) + {{16{$past(m[15])}}, $past(m)}) == '0))
        else $error("record missing");
endmodule
bind integer_add_and_logic_alu alu_checker_sva chk (.clock_i(clock_i), .resetn_i(resetn_i),
    .req_i(req_i), .wb_o(wb_o), .result_flag_field_o(result_flag_field_o),
    .unsigned_out_flag_o(unsigned_out_flag_o), .signed_overflow_flag_o(signed_overflow_flag_o));
`default_nettype wire

// File: verification/alu_decode_model.sv
// register-read stage model that issues operand requests
`timescale 1ns/10ps
`default_nettype none
module alu_decode_model (
    // clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // command in, request out
    input wire alu_pkg::alu_req_type cmd_i,
    output alu_pkg::alu_req_type req_o
);
    // idle cycles scramble operands so stale values never pass for live ones
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            req_o <= '0;
        end else if (cmd_i.valid) begin
            req_o <= cmd_i;
        end else begin
            req_o <= {1'b0, ~req_o[$bits(req_o)-2:0]};
        end
    end
endmodule
`default_nettype wire

// File: verification/integer_add_and_logic_alu_bench.sv
// self-checking bench for the add and logic datapath
`timescale 1ns/10ps
`default_nettype none
module integer_add_and_logic_alu_bench;
    typedef struct {
        alu_pkg::alu_op_type op;
        logic [31:0] a, b;
        logic [15:0] imm;
        logic [31:0] d;
        logic c;
    } row_type;
    logic clock_i, resetn_i, ca, ov;
    alu_pkg::alu_req_type cmd, req;
    alu_pkg::alu_wb_type wb;
    alu_pkg::result_field_type rf;
    int n_fail, n_checks;
    row_type rows[11];
    alu_decode_model model (.clock_i(clock_i), .resetn_i(resetn_i), .cmd_i(cmd), .req_o(req));
    integer_add_and_logic_alu dut (.clock_i(clock_i), .resetn_i(resetn_i), .req_i(req),
        .wb_o(wb), .result_flag_field_o(rf), .unsigned_out_flag_o(ca), .signed_overflow_flag_o(ov));
    task automatic chk(input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic run(input alu_pkg::alu_op_type op, input logic [31:0] a, b,
        input logic [15:0] imm, input logic [4:0] ai, input logic oe, rc);
        @(posedge clock_i);
        cmd <= '{1'b1, op, 5'h03, ai, a, b, a, imm, oe, rc};
        @(posedge clock_i);
        cmd.valid <= 1'b0;
        @(posedge clock_i);
        #1;
    endtask
    task automatic end_sim();
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    initial begin
        #20000;
        n_fail++;
        end_sim();
    end
    initial begin
        resetn_i = 1'b0;
        cmd = '0;
        rows = '{'{alu_pkg::OP_SUM_CARRY, 32'hFFFF_FFFF, 32'h0000_0001, '0, '0, 1'b1},
            '{alu_pkg::OP_SUM_ZERO, 32'hFFFF_FFFF, '0, '0, '0, 1'b1},
            '{alu_pkg::OP_SUM_EXT, 32'h0000_0001, 32'h0000_0002, '0, 32'h0000_0004, '0},
            '{alu_pkg::OP_SUM_MINUS_ONE, 32'h0000_0005, '0, '0, 32'h0000_0004, 1'b1},
            '{alu_pkg::OP_SUM_IMM, 32'h0000_0010, '0, 16'hFFFE, 32'h0000_000E, 1'b1},
            '{alu_pkg::OP_SUM_IMM_HIGH, 32'h0000_0001, '0, 16'h0002, 32'h0002_0001, 1'b1},
            '{alu_pkg::OP_SUM_IMM_CARRY, '0, '0, 16'hFFFF, 32'hFFFF_FFFF, '0},
            '{alu_pkg::OP_AND_COMPL, 32'h0000_F0F0, 32'h0000_FF00, '0, 32'h0000_00F0, '0},
            '{alu_pkg::OP_AND_IMM_LOW, 32'h1234_5678, '0, 16'hFF00, 32'h0000_5600, '0},
            '{alu_pkg::OP_AND_IMM_HIGH, 32'h1234_5678, '0, 16'hFF00, 32'h1200_0000, '0},
            '{alu_pkg::OP_SUM_IMM_CARRY_REC, 32'hFFFF_FFFF, '0, 16'h0001, '0, 1'b1}};
        repeat (6) @(posedge clock_i);
        resetn_i <= 1'b1;
        foreach (rows[i]) begin
            run(rows[i].op, rows[i].a, rows[i].b, rows[i].imm, 5'h01, 1'b0, 1'b0);
            chk(wb.data, rows[i].d);
            chk(ca, rows[i].c);
            chk(wb.dest_idx, rows[i].op >= alu_pkg::OP_AND ? 5'h01 : 5'h03);
        end
        chk(rf, 4'b0010);
        run(alu_pkg::OP_SUM_IMM, 32'h0000_0005, '0, 16'h8000, 5'h00, 1'b0, 1'b0);
        chk(wb.data, 32'hFFFF_8000);
        run(alu_pkg::OP_SUM, 32'h8000_0000, '0, '0, 5'h01, 1'b0, 1'b1);
        chk(rf, 4'b1000);
        run(alu_pkg::OP_SUM, 32'h7FFF_FFFF, 32'h0000_0001, '0, 5'h01, 1'b1, 1'b0);
        chk(wb.data, 32'h8000_0000);
        chk(ov, 1'b1);
        chk(rf, 4'b1001);
        run(alu_pkg::OP_SUM_CARRY, 32'h7FFF_FFFF, 32'h0000_0001, '0, 5'h01, 1'b1, 1'b1);
        chk(ov, 1'b1);
        chk(rf, 4'b1001);
        run(alu_pkg::OP_AND, 32'h0000_F0F0, 32'h0000_FF00, '0, 5'h01, 1'b0, 1'b0);
        chk(wb.data, 32'h0000_F000);
        chk(rf, 4'b1001);
        run(alu_pkg::OP_AND_IMM_HIGH, 32'h1234_5678, '0, '0, 5'h01, 1'b0, 1'b0);
        chk(rf, 4'b0011);
        resetn_i <= 1'b0;
        @(posedge clock_i);
        #1;
        chk({wb.valid, rf, ca, ov}, '0);
        end_sim();
    end
endmodule
`default_nettype wire
